// ---- hdl/sbd_pkg.sv ----
// constants, types and behaviour summary for the skip and branch decode unit
// Behaviour
// - skip on set I/O bit advances pc by 2 or 3, 1 to 3 cycles
// - status-bit-set branch loads pc plus offset plus one when bit is one
// - status-bit-clear branch loads pc plus offset plus one when bit is zero
// - equal branch taken only when zero flag is one
// - not-equal branch taken only when zero flag is zero
// - carry-set branch taken when carry is one, falls through otherwise
// - carry-clear branch taken only when carry is zero
// - same-or-higher branch taken when carry is zero, as carry-clear
// - lower branch taken when carry is one, as carry-set
// - minus branch taken only when negative flag is one
// - plus branch taken only when negative flag is zero
// - signed greater-or-equal taken when negative xor overflow is zero
// - signed less-than taken when negative xor overflow is one
// - half-carry-set branch taken only when half carry is one
// - half-carry-clear branch taken only when half carry is zero
// - copy-bit-set branch taken only when copy storage flag is one
// - copy-bit-clear taken when flag zero; flags untouched; 1 or 2 cycles
package sbd_pkg;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_SKIP_IO_BIT_SET,
    OP_BRANCH_STATUS_BIT_SET,
    OP_BRANCH_STATUS_BIT_CLEAR,
    OP_BRANCH_EQUAL,
    OP_BRANCH_NOT_EQUAL,
    OP_BRANCH_CARRY_SET,
    OP_BRANCH_CARRY_CLEAR,
    OP_BRANCH_SAME_OR_HIGHER,
    OP_BRANCH_LOWER,
    OP_BRANCH_MINUS,
    OP_BRANCH_PLUS,
    OP_BRANCH_SIGNED_GE,
    OP_BRANCH_SIGNED_LT,
    OP_BRANCH_HALF_CARRY_SET,
    OP_BRANCH_HALF_CARRY_CLEAR,
    OP_BRANCH_COPY_BIT_SET,
    OP_BRANCH_COPY_BIT_CLEAR
  } sbd_op_e;

  // status register bit positions
  localparam logic [2:0] FLAG_CARRY      = 3'h0;
  localparam logic [2:0] FLAG_ZERO       = 3'h1;
  localparam logic [2:0] FLAG_NEGATIVE   = 3'h2;
  localparam logic [2:0] FLAG_OVERFLOW   = 3'h3;
  localparam logic [2:0] FLAG_HALF_CARRY = 3'h5;
  localparam logic [2:0] FLAG_COPY_BIT   = 3'h6;

  localparam int unsigned STATUS_W = 8;
  localparam int unsigned IO_W     = 8;
  localparam int unsigned BITSEL_W = 3;
  localparam int unsigned PC_W_DEF = 16;
  localparam int unsigned OFS_W_DEF = 7;

  // cycle counts
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // program counter steps in words
  localparam int unsigned STEP_SEQ   = 1;
  localparam int unsigned STEP_SKIP1 = 2;
  localparam int unsigned STEP_SKIP2 = 3;

endpackage

// ---- hdl/sbd_cond_eval.sv ----
// condition evaluation for skip and branch operations
`timescale 1ns/1ps
`default_nettype none
module sbd_cond_eval (
  input  wire sbd_pkg::sbd_op_e                   opCode,
  input  wire logic [sbd_pkg::BITSEL_W-1:0]       bitSel,
  input  wire logic [sbd_pkg::STATUS_W-1:0]       statusReg,
  input  wire logic [sbd_pkg::IO_W-1:0]           ioData,
  output logic                                    condMet,
  output logic                                    isSkip,
  output logic                                    isBranch
);
  import sbd_pkg::*;

  logic nXorV;

  assign nXorV = statusReg[FLAG_NEGATIVE] ^ statusReg[FLAG_OVERFLOW];

  always_comb begin
    condMet  = 1'b0;
    isSkip   = 1'b0;
    isBranch = 1'b1;
    case (opCode)
      OP_SKIP_IO_BIT_SET: begin
        isSkip   = 1'b1;
        isBranch = 1'b0;
        condMet  = ioData[bitSel];
      end
      OP_BRANCH_STATUS_BIT_SET:   condMet = statusReg[bitSel];
      OP_BRANCH_STATUS_BIT_CLEAR: condMet = ~statusReg[bitSel];
      OP_BRANCH_EQUAL:            condMet = statusReg[FLAG_ZERO];
      OP_BRANCH_NOT_EQUAL:        condMet = ~statusReg[FLAG_ZERO];
      OP_BRANCH_CARRY_SET:        condMet = statusReg[FLAG_CARRY];
      OP_BRANCH_CARRY_CLEAR:      condMet = ~statusReg[FLAG_CARRY];
      OP_BRANCH_SAME_OR_HIGHER:   condMet = ~statusReg[FLAG_CARRY];
      OP_BRANCH_LOWER:            condMet = statusReg[FLAG_CARRY];
      OP_BRANCH_MINUS:            condMet = statusReg[FLAG_NEGATIVE];
      OP_BRANCH_PLUS:             condMet = ~statusReg[FLAG_NEGATIVE];
      OP_BRANCH_SIGNED_GE:        condMet = ~nXorV;
      OP_BRANCH_SIGNED_LT:        condMet = nXorV;
      OP_BRANCH_HALF_CARRY_SET:   condMet = statusReg[FLAG_HALF_CARRY];
      OP_BRANCH_HALF_CARRY_CLEAR: condMet = ~statusReg[FLAG_HALF_CARRY];
      OP_BRANCH_COPY_BIT_SET:     condMet = statusReg[FLAG_COPY_BIT];
      OP_BRANCH_COPY_BIT_CLEAR:   condMet = ~statusReg[FLAG_COPY_BIT];
      default: begin
        isBranch = 1'b0;
        condMet  = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// ---- hdl/sbd_skip_branch_decode.sv ----
// skip and conditional branch sequencer with program counter update
`timescale 1ns/1ps
`default_nettype none
module sbd_skip_branch_decode #(
  parameter int unsigned PC_W  = sbd_pkg::PC_W_DEF,
  parameter int unsigned OFS_W = sbd_pkg::OFS_W_DEF
) (
  input  wire logic                              clock,
  input  wire logic                              rst_n,
  input  wire logic                              start,
  input  wire sbd_pkg::sbd_op_e                  opCode,
  input  wire logic [sbd_pkg::BITSEL_W-1:0]      bitSel,
  input  wire logic [OFS_W-1:0]                  offset,
  input  wire logic [PC_W-1:0]                   pcIn,
  input  wire logic [sbd_pkg::STATUS_W-1:0]      statusReg,
  input  wire logic [sbd_pkg::IO_W-1:0]          ioData,
  input  wire logic                              nextIsTwoWord,
  output logic                                   busy,
  output logic                                   done,
  output logic                                   pcLoad,
  output logic [PC_W-1:0]                        pcOut,
  output logic                                   taken,
  output logic [1:0]                             cyclesUsed,
  output logic                                   discardFetch,
  output logic                                   refused,
  output logic                                   illegalOp,
  output logic [sbd_pkg::STATUS_W-1:0]           statusOut
);
  import sbd_pkg::*;

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } sbd_state_e;

  sbd_state_e             state_q;
  sbd_state_e             state_d;

  logic                   condMet;
  logic                   isSkip;
  logic                   isBranch;
  logic                   accept;

  logic [PC_W-1:0]        ofsExt;
  logic [PC_W-1:0]        pcSeq;
  logic [PC_W-1:0]        pcBranch;
  logic [PC_W-1:0]        pcSkip;
  logic [PC_W-1:0]        target_d;
  logic [1:0]             total_d;
  logic                   taken_d;

  logic [1:0]             remain_q;
  logic [PC_W-1:0]        target_q;
  logic [1:0]             total_q;
  logic                   takenHeld_q;
  logic                   finish;

  logic                   busy_q;
  logic                   done_q;
  logic                   pcLoad_q;
  logic [PC_W-1:0]        pcOut_q;
  logic                   taken_q;
  logic [1:0]             cyclesUsed_q;
  logic                   discard_q;
  logic                   refused_q;
  logic                   illegal_q;
  logic [STATUS_W-1:0]    status_q;

  sbd_cond_eval sbd_cond_eval_inst (
    .opCode    (opCode),
    .bitSel    (bitSel),
    .statusReg (statusReg),
    .ioData    (ioData),
    .condMet   (condMet),
    .isSkip    (isSkip),
    .isBranch  (isBranch)
  );

  assign accept = start && (state_q == ST_IDLE);

  assign ofsExt = {{(PC_W-OFS_W){offset[OFS_W-1]}}, offset};

  assign pcSeq = pcIn + PC_W'(STEP_SEQ);

  assign pcBranch = pcSeq + ofsExt;

  // step over one or two words
  assign pcSkip = nextIsTwoWord ? pcIn + PC_W'(STEP_SKIP2)
                                : pcIn + PC_W'(STEP_SKIP1);

  // target, cycle count and outcome of the accepted operation
  always_comb begin
    target_d = pcSeq;
    total_d  = CYC_ONE;
    taken_d  = 1'b0;
    if (isSkip && condMet) begin
      target_d = pcSkip;
      total_d  = nextIsTwoWord ? CYC_THREE : CYC_TWO;
      taken_d  = 1'b1;
    end else if (isBranch && condMet) begin
      target_d = pcBranch;
      total_d  = CYC_TWO;
      taken_d  = 1'b1;
    end
  end

  assign finish = (state_q == ST_RUN) && (remain_q == CYC_ONE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (accept && (total_d != CYC_ONE)) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (finish) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // remaining cycles of a multi-cycle operation
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      remain_q <= 2'h0;
    end else if (accept) begin
      remain_q <= total_d - CYC_ONE;
    end else if (state_q == ST_RUN) begin
      remain_q <= remain_q - CYC_ONE;
    end
  end

  // captured result of the accepted operation
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      target_q    <= '0;
      total_q     <= 2'h0;
      takenHeld_q <= 1'b0;
    end else if (accept) begin
      target_q    <= target_d;
      total_q     <= total_d;
      takenHeld_q <= taken_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_d == ST_RUN);
    end
  end

  // completion after one, two or three cycles
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (accept && (total_d == CYC_ONE)) || finish;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pcLoad_q <= 1'b0;
      pcOut_q  <= '0;
    end else if (accept && (total_d == CYC_ONE)) begin
      pcLoad_q <= 1'b1;
      pcOut_q  <= target_d;
    end else if (finish) begin
      pcLoad_q <= 1'b1;
      pcOut_q  <= target_q;
    end else begin
      pcLoad_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      taken_q      <= 1'b0;
      cyclesUsed_q <= 2'h0;
    end else if (accept && (total_d == CYC_ONE)) begin
      taken_q      <= taken_d;
      cyclesUsed_q <= total_d;
    end else if (finish) begin
      taken_q      <= takenHeld_q;
      cyclesUsed_q <= total_q;
    end
  end

  // fetched words dropped while a taken skip or branch runs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      discard_q <= 1'b0;
    end else begin
      discard_q <= (state_d == ST_RUN);
    end
  end

  // start while busy is ignored
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= start && (state_q != ST_IDLE);
    end
  end

  // unknown opcode falls through in one cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= accept && !isSkip && !isBranch;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
    end else if (accept) begin
      status_q <= statusReg;
    end
  end

  assign busy         = busy_q;
  assign done         = done_q;
  assign pcLoad       = pcLoad_q;
  assign pcOut        = pcOut_q;
  assign taken        = taken_q;
  assign cyclesUsed   = cyclesUsed_q;
  assign discardFetch = discard_q;
  assign refused      = refused_q;
  assign illegalOp    = illegal_q;
  assign statusOut    = status_q;

endmodule
`default_nettype wire

// ---- dv/sbd_skip_branch_decode_assertions.sv ----
// port-level checker for the skip and branch decode unit
`timescale 1ns/1ps
`default_nettype none
module sbd_skip_branch_decode_checker #(
  parameter int unsigned PC_W  = 16,
  parameter int unsigned OFS_W = 7
) (
  input wire logic                         clock,
  input wire logic                         rst_n,
  input wire logic                         start,
  input wire sbd_pkg::sbd_op_e             opCode,
  input wire logic [sbd_pkg::BITSEL_W-1:0] bitSel,
  input wire logic [OFS_W-1:0]             offset,
  input wire logic [PC_W-1:0]              pcIn,
  input wire logic [sbd_pkg::STATUS_W-1:0] statusReg,
  input wire logic [sbd_pkg::IO_W-1:0]     ioData,
  input wire logic                         nextIsTwoWord,
  input wire logic                         busy,
  input wire logic                         done,
  input wire logic                         pcLoad,
  input wire logic [PC_W-1:0]              pcOut,
  input wire logic                         taken,
  input wire logic [1:0]                   cyclesUsed,
  input wire logic                         discardFetch,
  input wire logic                         refused,
  input wire logic                         illegalOp,
  input wire logic [sbd_pkg::STATUS_W-1:0] statusOut
);
  import sbd_pkg::*;
  logic            acc;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] tgt;
  logic [OFS_W-1:0] ofs_q;
  logic [7:0]      st_q;
  logic [2:0]      cnt_q;
  sbd_op_e         op_q;
  assign acc = start && !busy;
  assign tgt = pc_q + PC_W'(1) + PC_W'($signed(ofs_q));
  // operands of the op in flight, and cycles since it was accepted
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_q  <= '0;
      ofs_q <= '0;
      st_q  <= '0;
      op_q  <= OP_NONE;
      cnt_q <= 3'h0;
    end else if (acc) begin
      pc_q  <= pcIn;
      ofs_q <= offset;
      st_q  <= statusReg;
      op_q  <= opCode;
      cnt_q <= 3'h1;
    end else if (cnt_q != 3'h7) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_done_pc_pulse: assert property ((done || pcLoad) |-> done && pcLoad)
    else $error("done and pcLoad not raised together");
  chk_done_one_cycle: assert property (done && !acc |=> !done)
    else $error("done held without a new accepted op");
  chk_cycle_count: assert property (done |-> cyclesUsed == cnt_q[1:0] && cnt_q < 3'h4)
    else $error("completion cycle does not match cyclesUsed");
  chk_discard_busy: assert property (discardFetch == busy)
    else $error("discardFetch differs from busy");
  chk_fall_target: assert property (done && !taken |-> pcOut == pc_q + PC_W'(1) && cyclesUsed == CYC_ONE)
    else $error("fall-through pc or cycles wrong");
  chk_branch_target: assert property (done && taken && op_q != OP_SKIP_IO_BIT_SET |-> pcOut == tgt && cyclesUsed == CYC_TWO)
    else $error("taken branch target or cycles wrong");
  chk_skip_step: assert property (done && taken && op_q == OP_SKIP_IO_BIT_SET |-> pcOut == pc_q + PC_W'(cyclesUsed) && cyclesUsed != CYC_ONE)
    else $error("skip step wrong");
  chk_equal_cond: assert property (done && op_q == OP_BRANCH_EQUAL |-> taken == st_q[FLAG_ZERO])
    else $error("equal branch decision wrong");
  chk_signed_lt: assert property (done && op_q == OP_BRANCH_SIGNED_LT |-> taken == (st_q[FLAG_NEGATIVE] ^ st_q[FLAG_OVERFLOW]))
    else $error("signed less-than decision wrong");
  chk_refuse_pulse: assert property (start && busy |=> refused)
    else $error("start while busy not refused");
  chk_status_kept: assert property (acc |=> statusOut == $past(statusReg))
    else $error("statusOut is not the accepted status");
  chk_illegal_fast: assert property (illegalOp |-> done && cyclesUsed == CYC_ONE && !taken)
    else $error("illegal op not a one-cycle fall-through");
  cov_skip_three: cover property (done && cyclesUsed == CYC_THREE);
  cov_branch_taken: cover property (done && taken && cyclesUsed == CYC_TWO);
  cov_refused: cover property (refused);
endmodule
bind sbd_skip_branch_decode sbd_skip_branch_decode_checker #(.PC_W(PC_W), .OFS_W(OFS_W)) chk_inst (
  .clock(clock), .rst_n(rst_n), .start(start), .opCode(opCode), .bitSel(bitSel), .offset(offset),
  .pcIn(pcIn), .statusReg(statusReg), .ioData(ioData), .nextIsTwoWord(nextIsTwoWord), .busy(busy),
  .done(done), .pcLoad(pcLoad), .pcOut(pcOut), .taken(taken), .cyclesUsed(cyclesUsed),
  .discardFetch(discardFetch), .refused(refused), .illegalOp(illegalOp), .statusOut(statusOut));
`default_nettype wire

// ---- dv/sbd_skip_branch_decode_tb.sv ----
// self-checking bench for the skip and branch decode unit
`timescale 1ns/1ps
`default_nettype none
module sbd_skip_branch_decode_tb;
  import sbd_pkg::*;
  logic        clock = 0, rst_n = 0, start = 0, nextIsTwoWord = 0;
  sbd_op_e     opCode = OP_NONE;
  logic [2:0]  bitSel = '0;
  logic [6:0]  offset = '0;
  logic [15:0] pcIn = '0, pcOut;
  logic [7:0]  statusReg = '0, ioData = '0, statusOut;
  logic        busy, done, pcLoad, taken, discardFetch, refused, illegalOp;
  logic [1:0]  cyclesUsed;
  int          fails = 0, comparisons = 0, seed = 32'h17D5;
  // flag tested per op (9 means N xor V) and ops taken on a set value
  localparam int FLG[18] = '{0, 0, 0, 0, 1, 1, 0, 0, 0, 0, 2, 2, 9, 9, 5, 5, 6, 6};
  localparam logic [17:0] SETM = 18'h16656;
  sbd_skip_branch_decode sbd_skip_branch_decode_inst (
    .clock(clock), .rst_n(rst_n), .start(start), .opCode(opCode), .bitSel(bitSel), .offset(offset),
    .pcIn(pcIn), .statusReg(statusReg), .ioData(ioData), .nextIsTwoWord(nextIsTwoWord), .busy(busy),
    .done(done), .pcLoad(pcLoad), .pcOut(pcOut), .taken(taken), .cyclesUsed(cyclesUsed),
    .discardFetch(discardFetch), .refused(refused), .illegalOp(illegalOp), .statusOut(statusOut));
  initial forever #5 clock = ~clock;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one op with random operands; poke repeats start while busy
  task automatic do_op(input int op, input bit poke);
    int k, n;
    logic t, v, ill;
    logic [15:0] pcX;
    logic [7:0] st;
    opCode = sbd_op_e'(op);
    statusReg = $random(seed);
    ioData = $random(seed);
    bitSel = $random(seed);
    offset = $random(seed);
    pcIn = $random(seed);
    nextIsTwoWord = $random(seed);
    start = 1;
    st = statusReg;
    ill = op == 0 || op > 17;
    t = 0;
    if (!ill) begin
      v = op == 1 ? ioData[bitSel] : op < 4 ? statusReg[bitSel] :
          FLG[op] == 9 ? statusReg[2] ^ statusReg[3] : statusReg[FLG[op]];
      t = SETM[op] ? v : !v;
    end
    n = !t ? 1 : (op == 1 && nextIsTwoWord) ? 3 : 2;
    pcX = !t ? pcIn + 16'h1 : op == 1 ? pcIn + 16'(n) : pcIn + 16'h1 + {{9{offset[6]}}, offset};
    @(negedge clock);
    // one-cycle ops keep start up for the next op; long ops scramble inputs
    if (n > 1) begin
      start = poke;
      statusReg = ~statusReg;
      pcIn = ~pcIn;
    end
    k = 1;
    while (done !== 1'b1 && k < 6) begin
      chk(busy, 1);
      @(negedge clock);
      k++;
      if (k == 2) chk(refused, poke && n > 1);
      if (done !== 1'b1 && start) start = 0;
    end
    chk(k, n);
    chk(busy, 0);
    chk(discardFetch, 0);
    chk(cyclesUsed, n);
    chk(taken, t);
    chk(pcOut, pcX);
    chk(pcLoad, 1);
    chk(illegalOp, ill);
    chk(statusOut, st);
  endtask
  initial begin
    repeat (4) @(negedge clock);
    rst_n = 1;
    for (int r = 0; r < 8; r++) begin
      for (int i = 0; i < 20; i++) do_op(i, r % 2 == 1);
      $display("round %0d finished", r);
    end
    give_verdict();
  end
  initial begin
    #50000;
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
